// file: rtl/srm_cfg.svh
// Constants of the shared RAM area manager
`ifndef SRM_CFG_SVH
`define SRM_CFG_SVH
`define SRM_DATA_W 16
`define SRM_ADDR_W 16
`define SRM_INT_WORDS 8192
`define SRM_INT_AW 13
`define SRM_INT_LIMIT 17'h02000
`define SRM_SP_RST_A 16'h0000
`define SRM_SP_RST_B 16'h0100
`define SRM_LUT_BASE_A 16'h0200
`define SRM_LUT_BASE_B 16'h0240
`define SRM_MC_RST 16'h0000
`define SRM_DS_STEP 8'h04
`define SRM_MT_STEP 8'h01
`define SRM_CUR_AREA_RST 1'b0
`define SRM_AREA_A 1'b0
`define SRM_AREA_B 1'b1
`define SRM_MEN_OUT_ON 1'b1
`endif

// file: rtl/srm_pkg.sv
// Types of the shared RAM area manager
package srm_pkg;
   typedef enum logic [1:0] {SRM_BC, SRM_RT, SRM_MT} srm_mode_t;
   typedef enum logic {SRM_ARB_FREE, SRM_ARB_HOST_OWED} srm_arb_t;
endpackage

// file: rtl/srm_ram.sv
// Internal word-wide shared RAM
`timescale 1ns/10ps
module srm_ram #(
   parameter int DEPTH = 8192,
   parameter int AW = 13,
   parameter int DW = 16
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [0:DEPTH-1];

   // Write port, one word per edge
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // Read is registered by the caller
   assign rdata_o = mem[addr_i];
endmodule

// file: rtl/srm_top.sv
// Shared RAM arbiter and area manager
`timescale 1ns/10ps
`include "srm_cfg.svh"
// Operation
// - Host and engine reach the shared memory one 16-bit word per access, host stalls one word at most.
// - Host reads and writes run during messages, arbitrated without host-visible change.
// - Memory holds two areas, A and B, each with its own stack and pointers in controller and terminal modes.
// - In controller and terminal modes each area has its own descriptor stack pointer.
// - In controller mode each area keeps its own message count for one frame.
// - In terminal mode each area has its own look-up table of data block addresses.
// - In monitor mode one single stack pointer gives the storage start address.
// - Data blocks sit anywhere in shared memory, reached by pointers of either area.
// - Address space is 8K words inside, extended externally to 64K with a 16-bit address.
// - The host picks the mode by software and the layout follows that mode.
// - The current area follows the select bit, 0 for A and 1 for B.
// - A change of current area waits until the message in progress ends.
module srm_top
   import srm_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic HOST_REQ_I,
   input wire logic HOST_WE_I,
   input wire logic [15:0] HOST_ADDR_I,
   input wire logic [15:0] HOST_WDATA_I,
   output logic HOST_GNT_O,
   output logic HOST_DONE_O,
   output logic [15:0] HOST_RDATA_O,
   input wire logic ENG_REQ_I,
   input wire logic ENG_WE_I,
   input wire logic [15:0] ENG_ADDR_I,
   input wire logic [15:0] ENG_WDATA_I,
   output logic ENG_GNT_O,
   output logic ENG_DONE_O,
   output logic [15:0] ENG_RDATA_O,
   input wire srm_mode_t HOST_MODE_I,
   input wire logic CFG_AREA_SEL_I,
   input wire logic MSG_ACTIVE_I,
   input wire logic SP_LOAD_I,
   input wire logic SP_LOAD_AREA_I,
   input wire logic [15:0] SP_LOAD_VAL_I,
   input wire logic SP_STEP_I,
   input wire logic MC_LOAD_I,
   input wire logic MC_LOAD_AREA_I,
   input wire logic [15:0] MC_LOAD_VAL_I,
   input wire logic MC_DEC_I,
   output logic CUR_AREA_O,
   output logic [15:0] STACK_PTR_O,
   output logic [15:0] LUT_BASE_O,
   output logic [15:0] MSG_CNT_O,
   output logic MSG_CNT_ZERO_O,
   input wire logic MEMORY_ENABLE_INPUT_I,
   output logic MEMORY_ENABLE_OUTPUT_O,
   output logic EXT_CS_O,
   output logic EXT_WE_O,
   output logic [15:0] EXT_ADDR_O,
   output logic [15:0] EXT_WDATA_O,
   input wire logic [15:0] EXT_RDATA_I
);
   srm_arb_t arb_r;
   logic host_gnt, eng_gnt, any_gnt, sel_internal;
   logic [15:0] sel_addr, st_addr_r, st_wdata_r, rdata_r, ram_rdata;
   logic st_vld_r, st_host_r, st_we_r, st_int_r, host_done_r, eng_done_r;
   logic men_s1_r, men_s2_r, men_s3_r, men_r, men_out_r, cur_area_r;
   logic [15:0] sp_r [0:1], mc_r [0:1];
   logic [7:0] sp_step;

   // Memory enable strap input, three-stage synchroniser
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         men_s1_r <= 1'b0;
         men_s2_r <= 1'b0;
         men_s3_r <= 1'b0;
      end else begin
         men_s1_r <= MEMORY_ENABLE_INPUT_I;
         men_s2_r <= men_s1_r;
         men_s3_r <= men_s2_r;
      end
   end

   // Accept a strap change once stages agree
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         men_r <= 1'b0;
      end else if (men_s2_r == men_s3_r) begin
         men_r <= men_s3_r;
      end
   end

   // Memory enable output, internal memory present
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         men_out_r <= 1'b0;
      end else begin
         men_out_r <= `SRM_MEN_OUT_ON;
      end
   end
   assign MEMORY_ENABLE_OUTPUT_O = men_out_r;

   always_comb begin
      eng_gnt = 1'b0;
      host_gnt = 1'b0;
      case (arb_r)
         SRM_ARB_FREE: begin
            eng_gnt = ENG_REQ_I;
            host_gnt = HOST_REQ_I & ~ENG_REQ_I;
         end
         SRM_ARB_HOST_OWED: begin
            host_gnt = HOST_REQ_I;
            eng_gnt = ENG_REQ_I & ~HOST_REQ_I;
         end
         default: host_gnt = 1'b0;
      endcase
   end
   assign any_gnt = host_gnt | eng_gnt;
   assign HOST_GNT_O = host_gnt;
   assign ENG_GNT_O = eng_gnt;

   // Host waits one word at most
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         arb_r <= SRM_ARB_FREE;
      end else if (HOST_REQ_I && !host_gnt) begin
         arb_r <= SRM_ARB_HOST_OWED;
      end else begin
         arb_r <= SRM_ARB_FREE;
      end
   end

   assign sel_addr = host_gnt ? HOST_ADDR_I : ENG_ADDR_I;
   assign sel_internal = men_r & ({1'b0, sel_addr} < `SRM_INT_LIMIT);

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         st_vld_r <= 1'b0;
         st_host_r <= 1'b0;
         st_we_r <= 1'b0;
         st_int_r <= 1'b0;
         st_addr_r <= 16'h0000;
         st_wdata_r <= 16'h0000;
      end else begin
         st_vld_r <= any_gnt;
         st_host_r <= host_gnt;
         st_we_r <= any_gnt & (host_gnt ? HOST_WE_I : ENG_WE_I);
         st_int_r <= sel_internal;
         st_addr_r <= sel_addr;
         st_wdata_r <= host_gnt ? HOST_WDATA_I : ENG_WDATA_I;
      end
   end

   // External static memory strobes from staged access
   assign EXT_CS_O = st_vld_r & ~st_int_r;
   assign EXT_WE_O = st_vld_r & ~st_int_r & st_we_r;
   assign EXT_ADDR_O = st_addr_r;
   assign EXT_WDATA_O = st_wdata_r;

   srm_ram #(
      .DEPTH(`SRM_INT_WORDS),
      .AW(`SRM_INT_AW),
      .DW(`SRM_DATA_W)
   ) u_ram (
      .clk_i(CLK_SYS_I),
      .we_i(st_vld_r & st_int_r & st_we_r),
      .addr_i(st_addr_r[`SRM_INT_AW-1:0]),
      .wdata_i(st_wdata_r),
      .rdata_o(ram_rdata)
   );

   // Return data and done to owner
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         rdata_r <= 16'h0000;
         host_done_r <= 1'b0;
         eng_done_r <= 1'b0;
      end else begin
         if (st_vld_r && !st_we_r) begin
            rdata_r <= st_int_r ? ram_rdata : EXT_RDATA_I;
         end
         host_done_r <= st_vld_r & st_host_r;
         eng_done_r <= st_vld_r & ~st_host_r;
      end
   end
   assign HOST_DONE_O = host_done_r;
   assign ENG_DONE_O = eng_done_r;
   assign HOST_RDATA_O = rdata_r;
   assign ENG_RDATA_O = rdata_r;

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         cur_area_r <= `SRM_CUR_AREA_RST;
      end else if (!MSG_ACTIVE_I) begin
         cur_area_r <= CFG_AREA_SEL_I;
      end
   end
   assign CUR_AREA_O = cur_area_r;

   assign sp_step = (HOST_MODE_I == SRM_MT) ? `SRM_MT_STEP : `SRM_DS_STEP;

   for (genvar g = 0; g < 2; g++) begin : g_area
      logic step_me;
      logic dec_me;
      assign step_me = SP_STEP_I &
         ((HOST_MODE_I == SRM_MT) ? (g == 0) : (cur_area_r == 1'(g)));
      assign dec_me = MC_DEC_I & (HOST_MODE_I == SRM_BC) & (cur_area_r == 1'(g));

      // High byte held, low byte wraps
      always_ff @(posedge CLK_SYS_I) begin
         if (RST_I) begin
            sp_r[g] <= (g == 0) ? `SRM_SP_RST_A : `SRM_SP_RST_B;
         end else if (SP_LOAD_I && SP_LOAD_AREA_I == 1'(g)) begin
            sp_r[g] <= SP_LOAD_VAL_I;
         end else if (step_me) begin
            sp_r[g] <= {sp_r[g][15:8], 8'(sp_r[g][7:0] + sp_step)};
         end
      end

      always_ff @(posedge CLK_SYS_I) begin
         if (RST_I) begin
            mc_r[g] <= `SRM_MC_RST;
         end else if (MC_LOAD_I && MC_LOAD_AREA_I == 1'(g)) begin
            mc_r[g] <= MC_LOAD_VAL_I;
         end else if (dec_me && mc_r[g] != 16'h0000) begin
            mc_r[g] <= 16'(mc_r[g] - 16'h0001);
         end
      end
   end
   assign STACK_PTR_O = (HOST_MODE_I == SRM_MT) ? sp_r[0] : sp_r[cur_area_r];
   assign LUT_BASE_O = (HOST_MODE_I != SRM_RT) ? 16'h0000 :
      (cur_area_r ? `SRM_LUT_BASE_B : `SRM_LUT_BASE_A);
   assign MSG_CNT_O = (HOST_MODE_I == SRM_BC) ? mc_r[cur_area_r] : 16'h0000;
   assign MSG_CNT_ZERO_O = (MSG_CNT_O == 16'h0000);
   // Checks
   property p_eng_first;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (ENG_REQ_I && HOST_REQ_I && arb_r == SRM_ARB_FREE) |-> (ENG_GNT_O && !HOST_GNT_O);
   endproperty
   a_eng_first: assert property (p_eng_first) else $error("engine not served first");
   property p_host_one_wait;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (HOST_REQ_I && !HOST_GNT_O) ##1 HOST_REQ_I |-> HOST_GNT_O;
   endproperty
   a_host_one_wait: assert property (p_host_one_wait) else $error("host stalled twice");
   property p_host_done;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      HOST_GNT_O |-> ##2 (HOST_DONE_O && !ENG_DONE_O);
   endproperty
   a_host_done: assert property (p_host_done) else $error("host access not done");
   property p_swap_hold;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      MSG_ACTIVE_I |=> $stable(CUR_AREA_O);
   endproperty
   a_swap_hold: assert property (p_swap_hold) else $error("area swapped mid message");
   property p_swap_take;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      !MSG_ACTIVE_I |=> (CUR_AREA_O == $past(CFG_AREA_SEL_I));
   endproperty
   a_swap_take: assert property (p_swap_take) else $error("area select not taken");
   property p_sp_step;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (SP_STEP_I && !SP_LOAD_I && HOST_MODE_I == SRM_BC
       && (MSG_ACTIVE_I || CFG_AREA_SEL_I == CUR_AREA_O))
      |=> (STACK_PTR_O == {$past(STACK_PTR_O[15:8]), 8'($past(STACK_PTR_O[7:0]) + 8'h04)});
   endproperty
   a_sp_step: assert property (p_sp_step) else $error("stack pointer step wrong");
   property p_mc_dec;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (MC_DEC_I && !MC_LOAD_I && HOST_MODE_I == SRM_BC && !MSG_CNT_ZERO_O
       && (MSG_ACTIVE_I || CFG_AREA_SEL_I == CUR_AREA_O))
      |=> (MSG_CNT_O == 16'($past(MSG_CNT_O) - 16'h0001));
   endproperty
   a_mc_dec: assert property (p_mc_dec) else $error("message count not decremented");
   property p_mt_single;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (HOST_MODE_I == SRM_MT && !SP_LOAD_I && !SP_STEP_I) ##1 (HOST_MODE_I == SRM_MT)
      |-> $stable(STACK_PTR_O);
   endproperty
   a_mt_single: assert property (p_mt_single) else $error("monitor pointer not single");
   property p_ext_range;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (ENG_GNT_O && ENG_ADDR_I[15:13] != 3'h0) |=> (EXT_CS_O && EXT_ADDR_O == $past(ENG_ADDR_I));
   endproperty
   a_ext_range: assert property (p_ext_range) else $error("high address not external");
endmodule

// file: verification/srm_ext_ram.sv
// External static word memory on the far side of the shared RAM manager
`timescale 1ns/10ps
module srm_ext_ram (
   input wire logic clk_i,
   input wire logic cs_i,
   input wire logic we_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output int hits_o
);
   logic [15:0] mem [0:65535];
   logic [15:0] last_r = 16'h0000;
   int cnt_r = 0;
   assign hits_o = cnt_r;
   always @(posedge clk_i) begin
      if (cs_i === 1'b1) begin
         cnt_r <= cnt_r + 1;
         if (we_i === 1'b1) begin
            mem[addr_i] <= wdata_i;
         end else begin
            last_r <= mem[addr_i];
         end
      end
   end
   // Released data lines show a changed value
   always_comb begin
      rdata_o = (cs_i === 1'b1 && we_i === 1'b0) ? mem[addr_i] : ~last_r;
   end
endmodule

// file: verification/shared_ram_area_manager_test.sv
// Self-checking bench of the shared RAM area manager
`timescale 1ns/10ps
module shared_ram_area_manager_test
   import srm_pkg::*;
;
   logic clk, rst, hreq, hwe, hgnt, hdone, ereq, ewe, egnt, edone, cs, xwe, tie, men_out;
   logic asel, mact, spl, spla, sps, mcl, mcla, mcd, cur, mcz;
   logic [15:0] haddr, hwd, hrd, eaddr, ewd, erd, splv, mclv, sp, lut, mc, xa, xwd, xrd;
   logic men_in;
   srm_mode_t mode;
   logic [15:0] ref_mem [0:65535];
   logic [15:0] adr [0:7];
   logic [15:0] corner [0:3] = '{16'h0000, 16'h1fff, 16'h2000, 16'hffff};
   int err_count = 0;
   int check_count = 0;
   int seed = 32'h67adda25;
   int hits;
   assign men_in = tie & men_out;
   // one system clock for all timing
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   srm_top i_srm_top (.CLK_SYS_I(clk), .RST_I(rst), .HOST_REQ_I(hreq), .HOST_WE_I(hwe),
      .HOST_ADDR_I(haddr), .HOST_WDATA_I(hwd), .HOST_GNT_O(hgnt), .HOST_DONE_O(hdone),
      .HOST_RDATA_O(hrd), .ENG_REQ_I(ereq), .ENG_WE_I(ewe), .ENG_ADDR_I(eaddr),
      .ENG_WDATA_I(ewd), .ENG_GNT_O(egnt), .ENG_DONE_O(edone), .ENG_RDATA_O(erd),
      .HOST_MODE_I(mode), .CFG_AREA_SEL_I(asel), .MSG_ACTIVE_I(mact), .SP_LOAD_I(spl),
      .SP_LOAD_AREA_I(spla), .SP_LOAD_VAL_I(splv), .SP_STEP_I(sps), .MC_LOAD_I(mcl),
      .MC_LOAD_AREA_I(mcla), .MC_LOAD_VAL_I(mclv), .MC_DEC_I(mcd), .CUR_AREA_O(cur),
      .STACK_PTR_O(sp), .LUT_BASE_O(lut), .MSG_CNT_O(mc), .MSG_CNT_ZERO_O(mcz),
      .MEMORY_ENABLE_INPUT_I(men_in), .MEMORY_ENABLE_OUTPUT_O(men_out), .EXT_CS_O(cs),
      .EXT_WE_O(xwe), .EXT_ADDR_O(xa), .EXT_WDATA_O(xwd), .EXT_RDATA_I(xrd));
   srm_ext_ram i_srm_ext_ram (.clk_i(clk), .cs_i(cs), .we_i(xwe), .addr_i(xa),
      .wdata_i(xwd), .rdata_o(xrd), .hits_o(hits));
   // Table base expected for a mode and area
   function automatic logic [15:0] exp_lut(input int m, input int a);
      return (m == 1) ? ((a == 1) ? 16'h0240 : 16'h0200) : 16'h0000;
   endfunction
   // Value compare with count
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Closing report
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One word access on engine (e=1) or host port
   task automatic acc(input bit e, input logic w, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      if (e) {ereq, ewe, eaddr, ewd} <= {1'b1, w, a, d};
      else {hreq, hwe, haddr, hwd} <= {1'b1, w, a, d};
      do begin
         @(negedge clk);
         n++;
      end while ((e ? egnt : hgnt) !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("grant wait", 16'h0001, 16'h0000);
         give_verdict;
      end
      @(posedge clk);
      if (e) ereq <= 1'b0;
      else hreq <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("done", 16'h0001, e ? edone : hdone);
      if (!w) chk("read data", ref_mem[a], e ? erd : hrd);
      else ref_mem[a] = d;
   endtask
   // Both ports ask in the same cycle
   task automatic clash(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      {ereq, ewe, eaddr, ewd} <= {1'b1, 1'b1, a, d};
      {hreq, hwe, haddr, hwd} <= {1'b1, 1'b1, a + 16'h0001, ~d};
      @(negedge clk);
      chk("engine grant", 16'h0001, egnt);
      chk("host held", 16'h0000, hgnt);
      @(posedge clk);
      ereq <= 1'b0;
      @(negedge clk);
      chk("host grant", 16'h0001, hgnt);
      @(posedge clk);
      hreq <= 1'b0;
      @(negedge clk);
      chk("engine done", 16'h0001, edone);
      @(posedge clk);
      @(negedge clk);
      chk("host done", 16'h0001, hdone);
      ref_mem[a] = d;
      ref_mem[a + 16'h0001] = ~d;
   endtask
   // Random writes then cross-port reads
   task automatic mem_phase(input bit inner);
      int h0;
      int nx;
      h0 = hits;
      nx = 0;
      clash(16'h1ffe, 16'($random(seed)));
      for (int i = 0; i < 8; i++) begin
         adr[i] = (i < 4) ? corner[i] : 16'($random(seed));
         nx += (adr[i] >= 16'h2000) ? 2 : 0;
         acc(i[0], 1'b1, adr[i], 16'($random(seed)));
      end
      for (int i = 7; i >= 0; i--) begin
         acc(!i[0], 1'b0, adr[i], 16'h0000);
      end
      acc(1'b1, 1'b0, 16'h1ffe, 16'h0000);
      chk("external hits", inner ? 16'(nx) : 16'h0013, 16'(hits - h0));
   endtask
   // Main sequence
   initial begin
      {hreq, hwe, haddr, hwd, ereq, ewe, eaddr, ewd} = '0;
      {asel, mact, spl, spla, splv, sps, mcl, mcla, mclv, mcd, tie} = '0;
      mode = SRM_BC;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("enable out in reset", 16'h0000, men_out);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("enable out", 16'h0001, men_out);
      chk("stack ptr", 16'h0000, sp);
      chk("count zero", 16'h0001, mcz);
      @(posedge clk);
      {asel, mact} <= 2'b11;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("area held", 16'h0000, cur);
      @(posedge clk);
      mact <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("area B", 16'h0001, cur);
      chk("area B ptr", 16'h0100, sp);
      @(posedge clk);
      {spl, spla, splv} <= {1'b1, 1'b1, 16'h00fe};
      @(posedge clk);
      {spl, sps} <= 2'b01;
      @(posedge clk);
      sps <= 1'b0;
      @(negedge clk);
      chk("wrapped ptr", 16'h0002, sp);
      @(posedge clk);
      {mcl, mcla, mclv} <= {1'b1, 1'b0, 16'h0003};
      @(posedge clk);
      {mcla, mclv} <= {1'b1, 16'h0001};
      @(posedge clk);
      {mcl, mcd} <= 2'b01;
      repeat (2) @(posedge clk);
      mcd <= 1'b0;
      @(negedge clk);
      chk("count B", 16'h0000, mc);
      chk("count zero B", 16'h0001, mcz);
      for (int a = 0; a < 2; a++) begin
         for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mode <= srm_mode_t'(m);
            asel <= a[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("table base", exp_lut(m, a), lut);
            chk("count", (m == 0 && a == 0) ? 16'h0003 : 16'h0000, mc);
            chk("ptr", (m == 2 || a == 0) ? 16'h0000 : 16'h0002, sp);
         end
      end
      @(posedge clk);
      sps <= 1'b1;
      @(posedge clk);
      sps <= 1'b0;
      @(negedge clk);
      chk("monitor ptr", 16'h0001, sp);
      mem_phase(1'b0);
      @(posedge clk);
      tie <= 1'b1;
      repeat (8) @(posedge clk);
      mem_phase(1'b1);
      give_verdict;
   end
endmodule
